// [rtl/ccg_pkg.sv]
package ccg_pkg;

   // ****************************************************************
   // register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] PROC_CLK_CTRL_OFS = 8'h00;
   localparam logic [7:0] MAIN_CLK_MODE_OFS = 8'h04;
   localparam logic [7:0] INT_OSC_MODE_OFS = 8'h08;
   localparam logic [7:0] MAIN_OSC_CTRL_OFS = 8'h0C;
   localparam logic [7:0] OSC_MODE_SEL_OFS = 8'h10;
   localparam logic [7:0] SUB_START_CTRL_OFS = 8'h14;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CPU_SUB_SEL_BIT = 4;
   localparam int CPU_SUB_STS_BIT = 5;
   localparam int MAIN_SRC_SEL_BIT = 0;
   localparam int MAIN_SRC_STS_BIT = 1;
   localparam int HS_HALT_BIT = 0;
   localparam int HS_STS_BIT = 7;
   localparam int MAIN_HALT_BIT = 7;
   localparam int MAIN_EXT_BIT = 7;
   localparam int MAIN_PIN_BIT = 6;
   localparam int SUB_EXT_BIT = 5;
   localparam int SUB_PIN_BIT = 4;
   localparam int AMP_BIT = 0;
   localparam int EARLY_BIT = 0;
   localparam int STALL_STS_BIT = 1;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic MAIN_OSC_HALT_RST = 1'b1;
   localparam logic INT_HS_OSC_HALT_RST = 1'b0;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam real CLK_MHZ = 200.0;
   localparam real STALL_MIN_US = 4.06;
   localparam real STALL_MAX_US = 16.12;
   localparam int STALL_MIN_CYC = int'($ceil(STALL_MIN_US * CLK_MHZ));
   localparam int STALL_MAX_CYC = int'($floor(STALL_MAX_US * CLK_MHZ));
   localparam int EXT_STALL_EDGES = 160;
   localparam logic [11:0] XTAL_STALL_LAST = 12'(STALL_MIN_CYC - 1);
   localparam logic [11:0] EXT_STALL_LAST = 12'(EXT_STALL_EDGES - 1);

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {SRC_INT_HS, SRC_MAIN, SRC_SUB} ccg_src_e;
   typedef enum logic [1:0] {ST_RUN, ST_XTAL, ST_EXT} ccg_stall_e;

endpackage : ccg_pkg

// [rtl/ccg_clk_switch.sv]
`timescale 1ns/1ps
module ccg_clk_switch
   import ccg_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic [2:0] src_lvl_in,
   input wire ccg_src_e target_in,
   input wire logic stall_in,
   output logic clk_out,
   output ccg_src_e active_out
);

   typedef struct packed {
      logic out;
      logic blocked;
      ccg_src_e cur;
   } ccg_switch_s;

   ccg_switch_s r;
   ccg_switch_s n;
   logic lvl;

   // ****************************************************************
   // glitch-free selection
   // ****************************************************************
   always_comb begin
      n = r;
      lvl = src_lvl_in[r.cur];
      // a high phase always runs to its end; new highs wait for release
      if (r.out) begin
         n.out = lvl;
      end else begin
         n.out = lvl & ~r.blocked & ~stall_in;
      end
      if (r.blocked && !lvl) begin
         n.blocked = 1'b0;
      end
      // hop only with both old level and output low; new source must
      // show a low before its first high passes, else half a phase
      if (target_in != r.cur && !r.out && !lvl) begin
         n.cur = target_in;
         n.blocked = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign clk_out = r.out;
   assign active_out = r.cur;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);

   stall_hold_low_a:
      assert property (stall_in && !clk_out |=> !clk_out)
      else $error("cpu clock rose during stall");

   hop_while_low_a:
      assert property (active_out != $past(active_out) |->
                       !clk_out && !$past(clk_out))
      else $error("source changed with clock high");

endmodule : ccg_clk_switch

// [rtl/ccg_cpu_clk_guard.sv]
`timescale 1ns/1ps
// Contract
// - crystal: cpu clock withheld 4.06 to 16.12 us after amp set
// - external main: cpu clock withheld 160 input clocks after amp set
// - hs oscillator halt honoured once cpu runs on main source
// - main halt stops crystal or external main input
// - on sub source, hs halt and main halt are honoured
// - clearing sub pin enable stops sub crystal or external input while early is clear
// - cpu sub select bit 4; main source select bit 0
// - hs status bit 7, hs halt bit 0
// - main source status is read-only bit 1
// - main halt is bit 7 of main oscillator control
// - ext, pin, sub ext, sub pin bits 7..4; amp bit 0
// - cpu sub status is read-only bit 5
module ccg_cpu_clk_guard
   import ccg_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic int_hs_clk_in,
   input wire logic main_clk_in,
   input wire logic sub_clk_in,
   input wire logic int_hs_ready_in,
   output logic int_hs_osc_en_out,
   output logic main_xtal_en_out,
   output logic main_ext_in_en_out,
   output logic sub_xtal_en_out,
   output logic sub_ext_in_en_out,
   output logic amp_high_out,
   output logic cpu_clk_out,
   output logic cpu_stall_out
);

   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic main_d;
      logic cpu_sub_sel;
      logic main_src_sel;
      logic main_sts;
      logic hs_halt;
      logic main_halt;
      logic main_ext;
      logic main_pin;
      logic sub_ext;
      logic sub_pin;
      logic amp;
      logic early;
      ccg_stall_e stall;
      logic [11:0] cnt;
      logic [31:0] rdata;
      logic [11:0] h_len;
      logic [7:0] h_edges;
   } ccg_guard_s;

   localparam ccg_guard_s GUARD_RST = '{
      main_halt: MAIN_OSC_HALT_RST,
      hs_halt: INT_HS_OSC_HALT_RST,
      stall: ST_RUN,
      default: '0};

   ccg_guard_s r;
   ccg_guard_s n;
   ccg_src_e active;
   ccg_src_e target;
   logic cpu_clk;
   logic main_edge;
   logic wr;
   logic amp_set;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic hit(input logic [7:0] a);
      return a == PROC_CLK_CTRL_OFS || a == MAIN_CLK_MODE_OFS ||
             a == INT_OSC_MODE_OFS || a == MAIN_OSC_CTRL_OFS ||
             a == OSC_MODE_SEL_OFS || a == SUB_START_CTRL_OFS;
   endfunction : hit

   function automatic logic [31:0] reg_word(input logic [7:0] a,
                                            input ccg_guard_s s,
                                            input ccg_src_e act);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         PROC_CLK_CTRL_OFS: begin
            w[CPU_SUB_SEL_BIT] = s.cpu_sub_sel;
            w[CPU_SUB_STS_BIT] = (act == SRC_SUB);
         end
         MAIN_CLK_MODE_OFS: begin
            w[MAIN_SRC_SEL_BIT] = s.main_src_sel;
            w[MAIN_SRC_STS_BIT] = s.main_sts;
         end
         INT_OSC_MODE_OFS: begin
            w[HS_HALT_BIT] = s.hs_halt;
            w[HS_STS_BIT] = s.sync2[3];
         end
         MAIN_OSC_CTRL_OFS: begin
            w[MAIN_HALT_BIT] = s.main_halt;
         end
         OSC_MODE_SEL_OFS: begin
            w[MAIN_EXT_BIT] = s.main_ext;
            w[MAIN_PIN_BIT] = s.main_pin;
            w[SUB_EXT_BIT] = s.sub_ext;
            w[SUB_PIN_BIT] = s.sub_pin;
            w[AMP_BIT] = s.amp;
         end
         SUB_START_CTRL_OFS: begin
            w[EARLY_BIT] = s.early;
            w[STALL_STS_BIT] = (s.stall != ST_RUN);
         end
         default: begin
         end
      endcase
      return w;
   endfunction : reg_word

   // ****************************************************************
   // source enables
   // ****************************************************************
   // halts act at once; software owns the rule of not halting the
   // source the cpu still runs on
   assign int_hs_osc_en_out = ~r.hs_halt;
   assign main_xtal_en_out = ~r.main_halt & r.main_pin &
                             ~r.main_ext;
   assign main_ext_in_en_out = ~r.main_halt & r.main_pin &
                               r.main_ext;
   assign sub_xtal_en_out = r.early | (r.sub_pin & ~r.sub_ext);
   assign sub_ext_in_en_out = ~r.early & r.sub_pin & r.sub_ext;
   assign amp_high_out = r.amp;

   assign target = r.cpu_sub_sel ? SRC_SUB :
                   (r.main_src_sel ? SRC_MAIN : SRC_INT_HS);
   assign main_edge = r.sync2[1] & ~r.main_d;
   assign wr = psel_in & penable_in & pwrite_in & hit(paddr_in);
   assign amp_set = pwdata_in[AMP_BIT] & ~r.amp & pwdata_in[MAIN_PIN_BIT];

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      n = r;
      n.sync1 = {int_hs_ready_in, sub_clk_in, main_clk_in, int_hs_clk_in};
      n.sync2 = r.sync1;
      n.main_d = r.sync2[1];
      if (active == SRC_MAIN) begin
         n.main_sts = 1'b1;
      end else if (active == SRC_INT_HS) begin
         n.main_sts = 1'b0;
      end else begin
         // main clock choice moves in the background while on sub
         n.main_sts = r.main_src_sel;
      end
      if (psel_in && !penable_in) begin
         n.rdata = reg_word(paddr_in, r, active);
      end
      case (r.stall)
         ST_RUN: begin
         end
         ST_XTAL: begin
            // shortest legal hold keeps the cpu waiting least
            if (r.cnt == XTAL_STALL_LAST) begin
               n.stall = ST_RUN;
            end else begin
               n.cnt = r.cnt + 12'h001;
            end
         end
         ST_EXT: begin
            // a dead input would freeze the cpu, so disabling it ends
            // the hold early
            if (!main_ext_in_en_out) begin
               n.stall = ST_RUN;
            end else if (main_edge) begin
               if (r.cnt == EXT_STALL_LAST) begin
                  n.stall = ST_RUN;
               end else begin
                  n.cnt = r.cnt + 12'h001;
               end
            end
         end
         default: begin
            n.stall = ST_RUN;
         end
      endcase
      if (wr) begin
         case (paddr_in)
            PROC_CLK_CTRL_OFS: begin
               n.cpu_sub_sel = pwdata_in[CPU_SUB_SEL_BIT];
            end
            MAIN_CLK_MODE_OFS: begin
               n.main_src_sel = pwdata_in[MAIN_SRC_SEL_BIT];
            end
            INT_OSC_MODE_OFS: begin
               n.hs_halt = pwdata_in[HS_HALT_BIT];
            end
            MAIN_OSC_CTRL_OFS: begin
               n.main_halt = pwdata_in[MAIN_HALT_BIT];
            end
            OSC_MODE_SEL_OFS: begin
               n.main_ext = pwdata_in[MAIN_EXT_BIT];
               n.main_pin = pwdata_in[MAIN_PIN_BIT];
               n.sub_ext = pwdata_in[SUB_EXT_BIT];
               n.sub_pin = pwdata_in[SUB_PIN_BIT];
               n.amp = pwdata_in[AMP_BIT];
               if (amp_set) begin
                  n.stall = pwdata_in[MAIN_EXT_BIT] ? ST_EXT :
                            ST_XTAL;
                  n.cnt = 12'h000;
               end
            end
            SUB_START_CTRL_OFS: begin
               n.early = pwdata_in[EARLY_BIT];
            end
            default: begin
            end
         endcase
      end
      n.h_len = (r.stall == ST_XTAL) ? r.h_len + 12'h001 : 12'h000;
      n.h_edges = (r.stall == ST_EXT) ?
                  r.h_edges + {7'h00, main_edge} : 8'h00;
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r <= GUARD_RST;
      end else begin
         r <= n;
      end
   end

   // ****************************************************************
   // cpu clock switch
   // ****************************************************************
   ccg_clk_switch u_switch (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .src_lvl_in(r.sync2[2:0]),
      .target_in(target),
      .stall_in(r.stall != ST_RUN),
      .clk_out(cpu_clk),
      .active_out(active)
   );

   assign cpu_clk_out = cpu_clk;
   assign cpu_stall_out = (r.stall != ST_RUN);
   assign prdata_out = r.rdata;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in & penable_in & ~hit(paddr_in);

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);

   sequence apb_wr(logic [7:0] ofs);
      psel_in && penable_in && pwrite_in && paddr_in == ofs;
   endsequence
   sequence apb_rd_setup(logic [7:0] ofs);
      psel_in && !penable_in && paddr_in == ofs;
   endsequence
   sequence xtal_exit;
      r.stall == ST_XTAL ##1 r.stall == ST_RUN;
   endsequence
   sequence ext_exit;
      r.stall == ST_EXT ##1 r.stall == ST_RUN && main_ext_in_en_out;
   endsequence

   xtal_stall_len_a:
      assert property (xtal_exit |-> r.h_len >= 12'(STALL_MIN_CYC) &&
                       r.h_len <= 12'(STALL_MAX_CYC))
      else $error("crystal stall length out of range");

   ext_stall_len_a:
      assert property (ext_exit |-> r.h_edges == 8'(EXT_STALL_EDGES))
      else $error("external stall not 160 input clocks");

   amp_starts_stall_a:
      assert property (apb_wr(OSC_MODE_SEL_OFS) and
                       (pwdata_in[AMP_BIT] && pwdata_in[MAIN_PIN_BIT] &&
                        !amp_high_out) |=> cpu_stall_out [*8])
      else $error("amp set did not stall cpu clock");

   hs_halt_pin_a:
      assert property (apb_wr(INT_OSC_MODE_OFS) and pwdata_in[HS_HALT_BIT]
                       |=> !int_hs_osc_en_out)
      else $error("hs halt not honoured");

   main_halt_pin_a:
      assert property (apb_wr(MAIN_OSC_CTRL_OFS) and
                       pwdata_in[MAIN_HALT_BIT]
                       |=> !main_xtal_en_out && !main_ext_in_en_out)
      else $error("main halt not honoured");

   sub_pin_off_a:
      assert property (apb_wr(OSC_MODE_SEL_OFS) and
                       !pwdata_in[SUB_PIN_BIT] && !r.early
                       |=> !sub_xtal_en_out && !sub_ext_in_en_out)
      else $error("sub source not disabled");

   sub_status_rd_a:
      assert property (apb_rd_setup(PROC_CLK_CTRL_OFS) |=>
                       prdata_out[CPU_SUB_STS_BIT] ==
                       ($past(active) == SRC_SUB))
      else $error("cpu sub status read wrong");

   main_status_a:
      assert property (active == SRC_MAIN |=> r.main_sts)
      else $error("main status not set");

   css_bit_pos_a:
      assert property (apb_wr(PROC_CLK_CTRL_OFS) and
                       pwdata_in[CPU_SUB_SEL_BIT] |=> target == SRC_SUB)
      else $error("cpu sub select not at bit 4");

   unmapped_err_a:
      assert property (psel_in && penable_in && !hit(paddr_in) |->
                       pslverr_out)
      else $error("unmapped access not flagged");

endmodule : ccg_cpu_clk_guard

// [verif/ccg_osc_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// oscillators and external clock inputs on the far side
// ****************************************************************
module ccg_osc_model (
   input wire logic int_hs_osc_en_in,
   input wire logic main_xtal_en_in,
   input wire logic main_ext_in_en_in,
   input wire logic sub_xtal_en_in,
   input wire logic sub_ext_in_en_in,
   output logic int_hs_clk_out,
   output logic main_clk_out,
   output logic sub_clk_out,
   output logic int_hs_ready_out
);
   int hs_run;

   initial begin
      hs_run = 0;
      int_hs_clk_out = 1'b0;
      main_clk_out = 1'b0;
      sub_clk_out = 1'b0;
      int_hs_ready_out = 1'b0;
   end

   // a stopped source stands low, never frozen high
   // start-up delay of 25 ticks before the running level is reported;
   // a level count, so the enable seen at time zero is not missed
   always begin
      #8;
      int_hs_clk_out = int_hs_osc_en_in ? ~int_hs_clk_out : 1'b0;
      if (int_hs_osc_en_in !== 1'b1) begin
         hs_run = 0;
      end else if (hs_run < 25) begin
         hs_run++;
      end
      int_hs_ready_out = (hs_run == 25);
   end

   always begin
      #10;
      main_clk_out = (main_xtal_en_in | main_ext_in_en_in) ?
         ~main_clk_out : 1'b0;
   end

   always begin
      #30;
      sub_clk_out = (sub_xtal_en_in | sub_ext_in_en_in) ?
         ~sub_clk_out : 1'b0;
   end

endmodule : ccg_osc_model

// [verif/ccg_cpu_clk_guard_tb.sv]
`timescale 1ns/1ps
module ccg_cpu_clk_guard_tb;
   import ccg_pkg::*;
   logic clk_sys_in;
   logic reset_n_in;
   logic psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr;
   logic hs_clk, main_clk, sub_clk, hs_ready;
   logic hs_en, x_en, xe_en, s_en, se_en, amp, cpu_clk, stall;
   int fail_count;
   int tests_run;
   int cnt, edges, lowbad;
   logic [31:0] r;
   logic e;

   ccg_cpu_clk_guard dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .int_hs_clk_in(hs_clk),
      .main_clk_in(main_clk), .sub_clk_in(sub_clk),
      .int_hs_ready_in(hs_ready), .int_hs_osc_en_out(hs_en),
      .main_xtal_en_out(x_en), .main_ext_in_en_out(xe_en),
      .sub_xtal_en_out(s_en), .sub_ext_in_en_out(se_en),
      .amp_high_out(amp), .cpu_clk_out(cpu_clk), .cpu_stall_out(stall));

   ccg_osc_model osc (.int_hs_osc_en_in(hs_en), .main_xtal_en_in(x_en),
      .main_ext_in_en_in(xe_en), .sub_xtal_en_in(s_en),
      .sub_ext_in_en_in(se_en), .int_hs_clk_out(hs_clk),
      .main_clk_out(main_clk), .sub_clk_out(sub_clk),
      .int_hs_ready_out(hs_ready));

   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // ****************************************************************
   // reporting
   // ****************************************************************
   task test_done;
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   task cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task chk(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask : chk

   // ****************************************************************
   // apb master
   // ****************************************************************
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys_in);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         chk(1'b0, "no ready");
         test_done();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // later compares see the outputs settled after the access edge
      @(negedge clk_sys_in);
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      cmp(e, 0);
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 0);
      cmp(r, exp);
      cmp(e, 0);
   endtask : rd

   task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      int n;
      for (n = 0; n < 200; n++) begin
         apb(1'b0, a, 0);
         if ((r & m) === x) break;
      end
      if (n == 200) begin
         chk(1'b0, "poll timeout");
         test_done();
      end
      cmp(r & m, x);
   endtask : poll

   // stall length in system cycles and main input edges seen meanwhile
   task stall_meas;
      logic last;
      int n;
      cnt = 0;
      edges = 0;
      lowbad = 0;
      last = main_clk;
      for (n = 0; n < 4000; n++) begin
         @(posedge clk_sys_in);
         if (stall === 1'b1) begin
            cnt++;
            if (main_clk === 1'b1 && last === 1'b0) edges++;
            if (cnt > 8 && cpu_clk !== 1'b0) lowbad = 1;
         end else if (cnt > 0) begin
            break;
         end
         last = main_clk;
      end
      if (n == 4000) begin
         chk(1'b0, "stall timeout");
         test_done();
      end
   endtask : stall_meas

   task clk_runs;
      int t;
      t = 0;
      repeat (100) begin
         @(posedge clk_sys_in);
         if (cpu_clk !== dut.cpu_clk_out) t = 0;
         if (cpu_clk === 1'b1) t++;
      end
      chk(t > 0 && t < 100, "cpu clock not running");
   endtask : clk_runs

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      fail_count = 0;
      tests_run = 0;
      reset_n_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (4) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      cmp(hs_en, 1);
      cmp(x_en, 0);
      rd(MAIN_OSC_CTRL_OFS, 32'h80);
      poll(INT_OSC_MODE_OFS, 32'h80, 32'h80);
      apb(1'b0, 8'h18, 0);
      cmp(r, 0);
      cmp(e, 1);
      // internal oscillator to main crystal
      wr(MAIN_OSC_CTRL_OFS, 32'h00);
      wr(OSC_MODE_SEL_OFS, 32'h40);
      cmp(x_en, 1);
      cmp(xe_en, 0);
      repeat (100) @(posedge clk_sys_in);
      wr(MAIN_CLK_MODE_OFS, 32'h01);
      poll(MAIN_CLK_MODE_OFS, 32'h03, 32'h03);
      wr(OSC_MODE_SEL_OFS, 32'h41);
      cmp(amp, 1);
      stall_meas();
      chk(cnt >= STALL_MIN_CYC &&
          cnt <= STALL_MAX_CYC, "xtal stall");
      cmp(lowbad, 0);
      clk_runs();
      wr(INT_OSC_MODE_OFS, 32'h01);
      cmp(hs_en, 0);
      poll(INT_OSC_MODE_OFS, 32'h81, 32'h01);
      // back to the internal oscillator
      wr(INT_OSC_MODE_OFS, 32'h00);
      poll(INT_OSC_MODE_OFS, 32'h80, 32'h80);
      wr(MAIN_CLK_MODE_OFS, 32'h00);
      poll(MAIN_CLK_MODE_OFS, 32'h02, 32'h00);
      wr(MAIN_OSC_CTRL_OFS, 32'h80);
      cmp(x_en, 0);
      // internal oscillator to external main clock
      wr(OSC_MODE_SEL_OFS, 32'h00);
      wr(MAIN_OSC_CTRL_OFS, 32'h00);
      wr(OSC_MODE_SEL_OFS, 32'hC0);
      cmp(xe_en, 1);
      cmp(x_en, 0);
      wr(MAIN_CLK_MODE_OFS, 32'h01);
      poll(MAIN_CLK_MODE_OFS, 32'h02, 32'h02);
      wr(OSC_MODE_SEL_OFS, 32'hC1);
      stall_meas();
      chk(edges >= 158 && edges <= 162, "ext stall edges");
      cmp(lowbad, 0);
      // main source to sub crystal
      wr(OSC_MODE_SEL_OFS, 32'hD1);
      cmp(s_en, 1);
      cmp(se_en, 0);
      repeat (100) @(posedge clk_sys_in);
      wr(PROC_CLK_CTRL_OFS, 32'h10);
      poll(PROC_CLK_CTRL_OFS, 32'h30, 32'h30);
      wr(MAIN_OSC_CTRL_OFS, 32'h80);
      cmp(xe_en, 0);
      wr(INT_OSC_MODE_OFS, 32'h01);
      cmp(hs_en, 0);
      clk_runs();
      // sub back to external main clock
      wr(INT_OSC_MODE_OFS, 32'h00);
      wr(MAIN_OSC_CTRL_OFS, 32'h00);
      poll(MAIN_CLK_MODE_OFS, 32'h02, 32'h02);
      wr(PROC_CLK_CTRL_OFS, 32'h00);
      poll(PROC_CLK_CTRL_OFS, 32'h30, 32'h00);
      clk_runs();
      wr(OSC_MODE_SEL_OFS, 32'hC1);
      cmp(s_en, 0);
      wr(OSC_MODE_SEL_OFS, 32'hF1);
      cmp(se_en, 1);
      cmp(s_en, 0);
      wr(SUB_START_CTRL_OFS, 32'h01);
      cmp(s_en, 1);
      cmp(se_en, 0);
      // sub and back to the internal oscillator
      wr(MAIN_CLK_MODE_OFS, 32'h00);
      poll(MAIN_CLK_MODE_OFS, 32'h02, 32'h00);
      wr(PROC_CLK_CTRL_OFS, 32'h10);
      poll(PROC_CLK_CTRL_OFS, 32'h30, 32'h30);
      poll(INT_OSC_MODE_OFS, 32'h81, 32'h80);
      poll(MAIN_CLK_MODE_OFS, 32'h02, 32'h00);
      wr(PROC_CLK_CTRL_OFS, 32'h00);
      poll(PROC_CLK_CTRL_OFS, 32'h30, 32'h00);
      clk_runs();
      // sub back to the main crystal
      wr(PROC_CLK_CTRL_OFS, 32'h10);
      poll(PROC_CLK_CTRL_OFS, 32'h30, 32'h30);
      wr(OSC_MODE_SEL_OFS, 32'h40);
      cmp(x_en, 1);
      repeat (100) @(posedge clk_sys_in);
      wr(MAIN_CLK_MODE_OFS, 32'h01);
      poll(MAIN_CLK_MODE_OFS, 32'h02, 32'h02);
      wr(PROC_CLK_CTRL_OFS, 32'h00);
      poll(PROC_CLK_CTRL_OFS, 32'h30, 32'h00);
      wr(OSC_MODE_SEL_OFS, 32'h41);
      stall_meas();
      chk(cnt >= STALL_MIN_CYC &&
          cnt <= STALL_MAX_CYC, "sub to xtal stall");
      cmp(lowbad, 0);
      clk_runs();
      test_done();
   end
endmodule : ccg_cpu_clk_guard_tb
